// ### hw/cbca_defines.vh
// constants for the bus-cycle sequencer and operand address generator
`ifndef CBCA_DEFINES_VH
`define CBCA_DEFINES_VH

// cycle type codes shown on cyc_type
`define CBCA_CYC_IDLE   3'h0
`define CBCA_CYC_FREE   3'h1
`define CBCA_CYC_FETCH  3'h2
`define CBCA_CYC_OPRD   3'h3
`define CBCA_CYC_OPWR   3'h4
`define CBCA_CYC_PUSH   3'h5
`define CBCA_CYC_POP    3'h6
`define CBCA_CYC_VECT   3'h7

// addressing mode codes on op_mode
`define CBCA_MODE_DIR        4'h0
`define CBCA_MODE_EXT        4'h1
`define CBCA_MODE_IX         4'h2
`define CBCA_MODE_IX1        4'h3
`define CBCA_MODE_IX2        4'h4
`define CBCA_MODE_IXPINC     4'h5
`define CBCA_MODE_IX1PINC    4'h6
`define CBCA_MODE_SP1        4'h7
`define CBCA_MODE_SP2        4'h8
`define CBCA_MODE_REL        4'h9

// page prefix byte, vector page, direct page
`define CBCA_PAGE2_PREFIX 8'h9e
`define CBCA_VECT_PAGE    8'hff
`define CBCA_DIR_PAGE     8'h00

// reset values
`define CBCA_PC_RST 16'h0000
`define CBCA_SP_RST 16'h00ff
`define CBCA_HX_RST 16'h0000

// sequencer states
`define CBCA_ST_RUN  2'h0
`define CBCA_ST_VEC2 2'h1
`define CBCA_ST_HALT 2'h2

`endif

// ### hw/cbca_sequencer.v
// bus-cycle sequencer and operand address generator of the 8-bit cpu
// How it works
// RULE_01: free cycle is one clock read
// RULE_02: fetch reads next program location, pc advances
// RULE_03: push writes one byte to stack
// RULE_04: pop reads one byte from stack
// RULE_05: vector read from top page, high first
// RULE_06: indexed address plus 16-bit offset
// RULE_07: indexed no offset, then index increments
// RULE_08: indexed 8-bit offset, then index increments
// RULE_09: stack pointer plus 8-bit offset
// RULE_10: stack pointer plus 16-bit offset
// RULE_11: branch reaches -128..+127 from next instruction
// RULE_12: direct address lies in first page
// RULE_13: prefix byte selects second opcode page
// RULE_14: wait clears interrupt mask, halts until interrupt
// RULE_15: each bus clock marked with its cycle type
`timescale 1ns/1ps
`include "cbca_defines.vh"

module cbca_sequencer (
    // clock and reset
    input wire sys_clk,
    input wire rst_b,
    // cycle request from the instruction decoder
    input wire op_valid,
    input wire [2:0] op_kind,
    input wire [3:0] op_mode,
    input wire [15:0] op_off,
    input wire [7:0] op_wdata,
    input wire [7:0] op_vect_lo,
    input wire op_wait,
    output reg op_ready_q,
    // register loads from the execution unit
    input wire ld_pc,
    input wire ld_sp,
    input wire ld_hx,
    input wire [15:0] ld_val,
    input wire imask_set,
    // interrupt pin, asynchronous
    input wire irq_pin,
    // system memory bus
    output reg [15:0] bus_addr_q,
    output reg bus_rd_q,
    output reg bus_wr_q,
    output reg [7:0] bus_wdata_q,
    input wire [7:0] bus_rdata,
    output reg [2:0] cyc_type_q,
    // captured read data and decoder state
    output reg [7:0] rdata_q,
    output reg rdata_valid_q,
    output reg page2_q,
    output reg [15:0] pc_q,
    output reg [15:0] sp_q,
    output reg [15:0] hx_q,
    output reg imask_q,
    output reg halted_q
);

    reg [1:0] state_q;
    reg [7:0] vect_lo_q;
    reg irq_s1_q;
    reg irq_s2_q;
    reg irq_s3_q;
    reg irq_q;
    reg [15:0] ea;
    reg postinc;
    wire take;
    wire [15:0] pc_inc;
    wire [15:0] rel_target;
    wire [15:0] sp_inc;
    wire [15:0] sp_dec;

    assign take = op_valid && op_ready_q;
    assign pc_inc = pc_q + 16'h0001;
    assign sp_inc = sp_q + 16'h0001;
    assign sp_dec = sp_q - 16'h0001;
    // RULE_11: sign-extended offset
    // pc already points past the branch, so the reach is relative to the next instruction
    assign rel_target = pc_q + {{8{op_off[7]}}, op_off[7:0]};

    // effective operand address by mode
    always @* begin
        ea = hx_q;
        postinc = 1'b0;
        case (op_mode)
            // RULE_12: direct page
            `CBCA_MODE_DIR: ea = {`CBCA_DIR_PAGE, op_off[7:0]};
            `CBCA_MODE_EXT: ea = op_off;
            `CBCA_MODE_IX: ea = hx_q;
            `CBCA_MODE_IX1: ea = hx_q + {8'h00, op_off[7:0]};
            // RULE_06: index plus 16-bit
            `CBCA_MODE_IX2: ea = hx_q + op_off;
            // RULE_07: index then increment
            `CBCA_MODE_IXPINC: begin
                ea = hx_q;
                postinc = 1'b1;
            end
            // RULE_08: 8-bit offset, increment
            `CBCA_MODE_IX1PINC: begin
                ea = hx_q + {8'h00, op_off[7:0]};
                postinc = 1'b1;
            end
            // RULE_09: stack plus 8-bit
            `CBCA_MODE_SP1: ea = sp_q + {8'h00, op_off[7:0]};
            // RULE_10: stack plus 16-bit
            `CBCA_MODE_SP2: ea = sp_q + op_off;
            default: ea = hx_q;
        endcase
    end

    // interrupt pin synchroniser; a change counts once stages two and three agree
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_s1_q <= 1'b0;
            irq_s2_q <= 1'b0;
            irq_s3_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_s1_q <= irq_pin;
            irq_s2_q <= irq_s1_q;
            irq_s3_q <= irq_s2_q;
            if (irq_s2_q == irq_s3_q) begin
                irq_q <= irq_s3_q;
            end
        end
    end

    // read data capture one clock after a read cycle is driven
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
            rdata_valid_q <= 1'b0;
            page2_q <= 1'b0;
        end else begin
            rdata_valid_q <= bus_rd_q && (cyc_type_q != `CBCA_CYC_FREE)
                && (cyc_type_q != `CBCA_CYC_IDLE);
            if (bus_rd_q) begin
                rdata_q <= bus_rdata;
            end
            // RULE_13: prefix marks next opcode
            // the flag stays up across non-fetch cycles and drops on the next fetch cycle, operand fetches included
            if (cyc_type_q == `CBCA_CYC_FETCH) begin
                page2_q <= (bus_rdata == `CBCA_PAGE2_PREFIX) && !page2_q;
            end
        end
    end

    // main sequencer: drives one bus cycle per taken request, two for a vector and none for a wait or an idle op_kind
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= `CBCA_ST_RUN;
            op_ready_q <= 1'b1;
            bus_addr_q <= 16'h0000;
            bus_rd_q <= 1'b0;
            bus_wr_q <= 1'b0;
            bus_wdata_q <= 8'h00;
            cyc_type_q <= `CBCA_CYC_IDLE;
            vect_lo_q <= 8'h00;
            pc_q <= `CBCA_PC_RST;
            sp_q <= `CBCA_SP_RST;
            hx_q <= `CBCA_HX_RST;
            imask_q <= 1'b1;
            halted_q <= 1'b0;
        end else begin
            // idle bus unless a cycle is started below
            bus_rd_q <= 1'b0;
            bus_wr_q <= 1'b0;
            cyc_type_q <= `CBCA_CYC_IDLE;
            if (imask_set) begin
                imask_q <= 1'b1;
            end
            case (state_q)
                `CBCA_ST_RUN: begin
                    if (take && op_wait) begin
                        // RULE_14: clear mask, halt
                        imask_q <= 1'b0;
                        halted_q <= 1'b1;
                        op_ready_q <= 1'b0;
                        state_q <= `CBCA_ST_HALT;
                    end else if (take) begin
                        // RULE_15: tag this cycle
                        cyc_type_q <= op_kind;
                        case (op_kind)
                            `CBCA_CYC_FREE: begin
                                // RULE_01: single read cycle
                                bus_rd_q <= 1'b1;
                                bus_addr_q <= pc_q;
                                if (op_mode == `CBCA_MODE_REL) begin
                                    pc_q <= rel_target;
                                end
                            end
                            `CBCA_CYC_FETCH: begin
                                // RULE_02: consecutive program read
                                bus_rd_q <= 1'b1;
                                bus_addr_q <= pc_q;
                                pc_q <= pc_inc;
                            end
                            `CBCA_CYC_OPRD, `CBCA_CYC_OPWR: begin
                                bus_rd_q <= (op_kind == `CBCA_CYC_OPRD);
                                bus_wr_q <= (op_kind == `CBCA_CYC_OPWR);
                                bus_wdata_q <= op_wdata;
                                bus_addr_q <= ea;
                                // RULE_07: increment after use
                                if (postinc) begin
                                    hx_q <= hx_q + 16'h0001;
                                end
                            end
                            `CBCA_CYC_PUSH: begin
                                // RULE_03: one byte write
                                bus_wr_q <= 1'b1;
                                bus_wdata_q <= op_wdata;
                                bus_addr_q <= sp_q;
                                sp_q <= sp_dec;
                            end
                            `CBCA_CYC_POP: begin
                                // RULE_04: one byte read
                                bus_rd_q <= 1'b1;
                                bus_addr_q <= sp_inc;
                                sp_q <= sp_inc;
                            end
                            `CBCA_CYC_VECT: begin
                                // RULE_05: high byte first
                                bus_rd_q <= 1'b1;
                                bus_addr_q <= {`CBCA_VECT_PAGE, op_vect_lo};
                                vect_lo_q <= op_vect_lo + 8'h01;
                                imask_q <= 1'b1;
                                op_ready_q <= 1'b0;
                                state_q <= `CBCA_ST_VEC2;
                            end
                            default: cyc_type_q <= `CBCA_CYC_IDLE;
                        endcase
                    end
                end
                `CBCA_ST_VEC2: begin
                    // RULE_05: low byte second
                    bus_rd_q <= 1'b1;
                    cyc_type_q <= `CBCA_CYC_VECT;
                    bus_addr_q <= {`CBCA_VECT_PAGE, vect_lo_q};
                    op_ready_q <= 1'b1;
                    state_q <= `CBCA_ST_RUN;
                end
                `CBCA_ST_HALT: begin
                    // RULE_14: wake on interrupt
                    // the pin wakes the core even if software set the mask again meanwhile
                    if (irq_q) begin
                        halted_q <= 1'b0;
                        op_ready_q <= 1'b1;
                        state_q <= `CBCA_ST_RUN;
                    end
                end
                default: begin
                    state_q <= `CBCA_ST_RUN;
                    op_ready_q <= 1'b1;
                end
            endcase
            // explicit loads override same-cycle sequencer updates
            if (ld_pc) begin
                pc_q <= ld_val;
            end
            if (ld_sp) begin
                sp_q <= ld_val;
            end
            if (ld_hx) begin
                hx_q <= ld_val;
            end
        end
    end

endmodule // cbca_sequencer

// ### verification/cbca_mem_model.sv
// memory and peripheral bus model standing on the far side of the sequencer
`timescale 1ns/1ps
module cbca_mem_model (
    // bus from the sequencer
    input wire logic sys_clk,
    input wire logic [15:0] bus_addr_q,
    input wire logic bus_rd_q,
    input wire logic bus_wr_q,
    input wire logic [7:0] bus_wdata_q,
    // read data back
    output logic [7:0] bus_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // preload a pattern the bench can predict from the address alone
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8);
        end
    end
    // writes land at the edge that ends the write cycle
    always @(posedge sys_clk) begin
        if (bus_wr_q) begin
            mem[bus_addr_q] <= bus_wdata_q;
        end
        if (bus_rd_q) begin
            last_q <= mem[bus_addr_q];
        end
    end
    // an idle bus shows the inverse of the last byte, so stale data never matches
    assign bus_rdata = bus_rd_q ? mem[bus_addr_q] : ~last_q;
endmodule // cbca_mem_model

// ### verification/cbca_seq_sva.sv
// assertion checker bound to the bus-cycle sequencer
`timescale 1ns/1ps
`include "cbca_defines.vh"
module cbca_seq_sva (
    // request side
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [2:0] op_kind,
    input wire logic [3:0] op_mode,
    input wire logic [15:0] op_off,
    input wire logic [7:0] op_vect_lo,
    input wire logic op_wait,
    input wire logic op_ready_q,
    // bus and registers
    input wire logic [15:0] bus_addr_q,
    input wire logic bus_rd_q,
    input wire logic bus_wr_q,
    input wire logic [2:0] cyc_type_q,
    input wire logic [15:0] pc_q,
    input wire logic [15:0] sp_q,
    input wire logic [15:0] hx_q,
    input wire logic imask_q,
    input wire logic halted_q
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // a plain request taken at this edge
    wire tk = op_valid && op_ready_q && !op_wait;
    // the two reads of a vector, high byte first
    sequence s_vhi;
        bus_rd_q && bus_addr_q == {8'hff, $past(op_vect_lo)} && !op_ready_q;
    endsequence
    sequence s_vlo;
        bus_rd_q && cyc_type_q == `CBCA_CYC_VECT
            && bus_addr_q == {8'hff, $past(bus_addr_q[7:0]) + 8'h01};
    endsequence
    AST_FREE: assert property (cyc_type_q == `CBCA_CYC_FREE |-> bus_rd_q && !bus_wr_q)
        else $error("free cycle is not a read");
    AST_FETCH: assert property (tk && op_kind == `CBCA_CYC_FETCH |=> bus_rd_q
        && bus_addr_q == $past(pc_q) && pc_q == $past(pc_q) + 16'h1) else $error("bad fetch");
    AST_PUSH: assert property (tk && op_kind == `CBCA_CYC_PUSH |=> bus_wr_q && !bus_rd_q
        && bus_addr_q == $past(sp_q) && sp_q == $past(sp_q) - 16'h1) else $error("bad push");
    AST_POP: assert property (tk && op_kind == `CBCA_CYC_POP |=> bus_rd_q && !bus_wr_q
        && sp_q == $past(sp_q) + 16'h1 && bus_addr_q == sp_q) else $error("bad pop");
    AST_VECT: assert property (tk && op_kind == `CBCA_CYC_VECT |=> s_vhi ##1 s_vlo)
        else $error("bad vector read");
    AST_IXPINC: assert property (tk && op_kind == `CBCA_CYC_OPRD
        && op_mode == `CBCA_MODE_IXPINC |=> bus_addr_q == $past(hx_q) && hx_q == bus_addr_q + 16'h1)
        else $error("bad post increment");
    AST_BRANCH: assert property (tk && op_kind == `CBCA_CYC_FREE && op_mode == `CBCA_MODE_REL
        |=> pc_q == $past(pc_q) + {{8{$past(op_off[7])}}, $past(op_off[7:0])})
        else $error("bad branch target");
    AST_WAIT: assert property (op_valid && op_ready_q && op_wait
        |=> halted_q && !imask_q && !op_ready_q) else $error("wait did not halt");
endmodule // cbca_seq_sva
bind cbca_sequencer cbca_seq_sva u_sva (.sys_clk, .rst_b, .op_valid, .op_kind, .op_mode, .op_off,
    .op_vect_lo, .op_wait, .op_ready_q, .bus_addr_q, .bus_rd_q, .bus_wr_q, .cyc_type_q, .pc_q,
    .sp_q, .hx_q, .imask_q, .halted_q);

// ### verification/cpu_bus_cycle_addressing_bench.sv
// self-checking bench for the bus-cycle sequencer against a reference model
`timescale 1ns/1ps
`include "cbca_defines.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[ERR] %0t got %h expected %h", $time, a, e); end end
module cpu_bus_cycle_addressing_bench;
    logic sys_clk = 0, rst_b = 0, op_valid = 0, op_wait = 0, irq_pin = 0, imask_set = 0;
    logic ld_pc = 0, ld_sp = 0, ld_hx = 0;
    logic [2:0] op_kind = 0;
    logic [3:0] op_mode = 0;
    logic [15:0] op_off = 0, ld_val = 0;
    logic [7:0] op_wdata = 0, op_vect_lo = 0;
    wire [15:0] bus_addr_q, pc_q, sp_q, hx_q;
    wire [7:0] bus_wdata_q, bus_rdata, rdata_q;
    wire [2:0] cyc_type_q;
    wire op_ready_q, bus_rd_q, bus_wr_q, rdata_valid_q, page2_q, imask_q, halted_q;
    int n_fail = 0, num_checks = 0, i;
    bit [15:0] pc, sp, hx;
    bit [31:0] seed = 32'h2891, r;
    logic [7:0] wm [int];
    cbca_sequencer u_dut (.sys_clk, .rst_b, .op_valid, .op_kind, .op_mode, .op_off, .op_wdata,
        .op_vect_lo, .op_wait, .op_ready_q, .ld_pc, .ld_sp, .ld_hx, .ld_val, .imask_set, .irq_pin,
        .bus_addr_q, .bus_rd_q, .bus_wr_q, .bus_wdata_q, .bus_rdata, .cyc_type_q, .rdata_q,
        .rdata_valid_q, .page2_q, .pc_q, .sp_q, .hx_q, .imask_q, .halted_q);
    cbca_mem_model u_mem (.sys_clk, .bus_addr_q, .bus_rd_q, .bus_wr_q, .bus_wdata_q, .bus_rdata);
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    function automatic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected byte: last write, else the preload pattern
    function automatic [7:0] mem_exp(input bit [15:0] a);
        return wm.exists(a) ? wm[a] : a[7:0] ^ a[15:8];
    endfunction
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // load pc (0), sp (1) or hx (2) while no request is pending
    task automatic ld(input int w, input bit [15:0] v);
        ld_val = v;
        {ld_hx, ld_sp, ld_pc} = 3'(1 << w);
        if (w == 0) pc = v; else if (w == 1) sp = v; else hx = v;
        tick();
        {ld_hx, ld_sp, ld_pc} = 3'h0;
    endtask
    // one request; model predicts address, registers and read data
    task automatic op(input bit [2:0] k, input bit [3:0] m, input bit [15:0] off);
        bit [15:0] ea;
        bit wr;
        ea = pc;
        wr = (k == `CBCA_CYC_OPWR || k == `CBCA_CYC_PUSH);
        case (k)
            `CBCA_CYC_FETCH: pc = pc + 1;
            `CBCA_CYC_FREE: if (m == `CBCA_MODE_REL) pc = pc + {{8{off[7]}}, off[7:0]};
            `CBCA_CYC_PUSH: begin ea = sp; sp = sp - 1; end
            `CBCA_CYC_POP: begin sp = sp + 1; ea = sp; end
            `CBCA_CYC_VECT: ea = {8'hff, off[7:0]};
            default: case (m)
                `CBCA_MODE_DIR: ea = {8'h00, off[7:0]};
                `CBCA_MODE_EXT: ea = off;
                `CBCA_MODE_IX, `CBCA_MODE_IXPINC: ea = hx;
                `CBCA_MODE_IX1, `CBCA_MODE_IX1PINC: ea = hx + off[7:0];
                `CBCA_MODE_IX2: ea = hx + off;
                `CBCA_MODE_SP1: ea = sp + off[7:0];
                default: ea = sp + off;
            endcase
        endcase
        if (k inside {`CBCA_CYC_OPRD, `CBCA_CYC_OPWR} && m inside {5, 6}) hx = hx + 1;
        op_valid = 1;
        {op_kind, op_mode, op_off, op_vect_lo, op_wdata} = {k, m, off, off[7:0], 8'(xs())};
        tick();
        op_valid = 0;
        `CHK({bus_addr_q, cyc_type_q, bus_rd_q, bus_wr_q}, {ea, k, !wr, wr})
        `CHK({pc_q, sp_q, hx_q}, {pc, sp, hx})
        if (wr) wm[ea] = op_wdata;
        if (wr) `CHK(bus_wdata_q, op_wdata)
        if (k == `CBCA_CYC_VECT) begin
            `CHK(op_ready_q, 1'b0)
            tick();
            ea = ea + 1;
            `CHK({bus_addr_q, imask_q, rdata_q}, {ea, 1'b1, mem_exp(ea - 1)})
        end
        tick();
        if (!wr && k != `CBCA_CYC_FREE) `CHK(rdata_q, mem_exp(ea))
        `CHK(rdata_valid_q, (!wr && k != `CBCA_CYC_FREE))
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst_b = 1;
        {pc, sp, hx} = {16'h0000, 16'h00ff, 16'h0000};
        ld(0, 16'h009e);
        ld(1, 16'h0480);
        ld(2, 16'hfff0);
        op(`CBCA_CYC_FETCH, 0, 0);
        `CHK(page2_q, 1'b1)
        op(`CBCA_CYC_FETCH, 0, 0);
        `CHK(page2_q, 1'b0)
        op(`CBCA_CYC_FREE, `CBCA_MODE_REL, 16'h0080);
        op(`CBCA_CYC_FREE, `CBCA_MODE_REL, 16'h007f);
        op(`CBCA_CYC_PUSH, 0, 0);
        op(`CBCA_CYC_POP, 0, 0);
        for (i = 0; i < 9; i++) op(`CBCA_CYC_OPWR, 4'(i), 16'(xs()));
        for (i = 0; i < 9; i++) op(`CBCA_CYC_OPRD, 4'(i), 16'(xs()));
        op(`CBCA_CYC_VECT, 0, 16'h00fe);
        // wait halts; a fetch offered meanwhile must be ignored
        {op_valid, op_wait} = 2'b11;
        tick();
        {op_wait, op_kind} = {1'b0, `CBCA_CYC_FETCH};
        repeat (3) tick();
        `CHK({halted_q, imask_q, bus_rd_q, pc_q}, {3'b100, pc})
        {irq_pin, op_valid} = 2'b10;
        for (i = 0; i < 20 && op_ready_q !== 1'b1; i++) tick();
        irq_pin = 0;
        `CHK({halted_q, op_ready_q}, 2'b01)
        if (i == 20) tally_and_finish();
        // a set pulse raises the mask cleared by the wait
        imask_set = 1;
        tick();
        imask_set = 0;
        `CHK(imask_q, 1'b1)
        for (i = 0; i < 60; i++) begin
            r = xs();
            op(3'(r % 6 + 1), 4'(r[11:8] % 9), r[31:16]);
        end
        tally_and_finish();
    end
endmodule // cpu_bus_cycle_addressing_bench
